/* src/thermal_overload_map.svh */
/*
  Constants of the thermal overload stage: levels, defaults and timing.
  Assumes a 40 MHz clock; included by bare name where needed.
*/
`ifndef THERMAL_OVERLOAD_MAP_SVH
`define THERMAL_OVERLOAD_MAP_SVH
`define CLK_HZ        40000000
`define ORDER_MAX     5'h0f
`define THETA_ONE     32'h0100_0000
`define THETA_INIT    32'h00b3_3333
`define COOL_NUM      40'h9
`define COOL_DEN      40'h64
`define REL_NUM       64'h5f
`define PCT_FULL      64'h64
`define KTH_ONE       16'h0100
`define DEF_K         16'h0100
`define DEF_ALARM     8'h3c
`define DEF_LIM40     8'h64
`define DEF_LIM70     8'h64
`define DEF_AMB       8'h28
`define DEF_TAU       16'h001e
`define DEF_CTAU      8'h10
`define AMB_LOW       40
`define AMB_SPAN      30
`define LN2_Q8        48'hb1
`define FORCE_MIN     5
`define FORCE_CYC     (36'(`FORCE_MIN) * 36'd60 * 36'(`CLK_HZ))
`define EVAL_MS       100
`define EVAL_CYC      (24'(`EVAL_MS) * 24'd40000)
`define EVAL_PER_MIN  (60000 / `EVAL_MS)
`endif

/* src/thermal_overload_pkg.sv */
/*
  Types of the thermal overload stage.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package thermal_overload_pkg;
  typedef struct packed {
    logic        valid;
    logic [1:0]  phase;
    logic [4:0]  order;
    logic [15:0] amp;
    logic        last;
  } harm_t;
  typedef enum logic [2:0] {
    SET_K = 3'h0, SET_ALARM = 3'h1, SET_LIM40 = 3'h2, SET_LIM70 = 3'h3,
    SET_AMB = 3'h4, SET_SENSOR = 3'h5, SET_TAU = 3'h6, SET_CTAU = 3'h7
  } setting_t;
  typedef struct packed {
    logic blocked;
    logic start;
    logic trip;
  } status_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] hours;
    logic [5:0]  minutes;
    logic [5:0]  seconds;
  } hms_t;
  typedef struct packed {
    logic [15:0]       k;
    logic [7:0]        alarm;
    logic [7:0]        lim40;
    logic [7:0]        lim70;
    logic signed [7:0] amb;
    logic [4:0]        sensor;
    logic [15:0]       tau;
    logic [7:0]        ctau;
  } settings_t;
endpackage

/* src/thermal_overload_model.sv */
/*
  Thermal overload stage: rms from harmonics, first-order heating model,
  start/trip with release levels, counters, time to trip, test forcing.
  Assumes all inputs come from logic on clk; harmonic amplitudes are rms.
*/
// Behaviour
// - rms from harmonics one to fifteen
// - model uses and reports highest phase current
// - preload current is sqrt(theta) times trip current
// - trip at 100 percent, rise shown in percent
// - start at settable alarm percentage
// - rise starts at 70 percent after reset
// - slow cooling below 0.3 motor rated current
// - cooling coefficient defaults to 1.0
// - trip current is k times kTheta times rated
// - ambient factor one in three listed cases
// - 40 degree load defaults 100 percent
// - ambient default 40, editable without sensor
// - sensor: none or one of sixteen inputs
// - shared force flag clears after five minutes
// - forced writes only while force flag set
// - clearable start and trip event counters
// - time to trip as hh:mm:ss
// - protected settings need password
`timescale 1ns/100ps
`include "thermal_overload_map.svh"
module thermal_overload_model #(
  parameter logic [35:0] FORCE_CYC = `FORCE_CYC,
  parameter logic [23:0] EVAL_CYC  = `EVAL_CYC,
  parameter int          PER_MIN   = `EVAL_PER_MIN
) (
  input  wire logic                            clk,
  input  wire logic                            nrst,
  input  wire thermal_overload_pkg::harm_t     harm,
  input  wire logic                            motorMode,
  input  wire logic [15:0]                     lineRated,
  input  wire logic [15:0]                     motorRatedCurrent,
  input  wire logic                            blockIn,
  input  wire logic [15:0][7:0]                externalAnalogueInput,
  input  wire logic                            setWr,
  input  wire thermal_overload_pkg::setting_t  setSel,
  input  wire logic [15:0]                     setData,
  input  wire logic                            passwordOk,
  input  wire logic                            forceReq,
  input  wire logic                            forceClr,
  input  wire logic                            frcWr,
  input  wire thermal_overload_pkg::status_t   frcStatus,
  input  wire logic [15:0]                     frcPct,
  input  wire logic                            startClr,
  input  wire logic                            tripClr,
  output var thermal_overload_pkg::status_t    status,
  output logic [15:0]                          thetaPct,
  output logic [15:0]                          highestPhaseCurrent,
  output logic [15:0]                          ambientCorrectedCurrent,
  output logic [15:0]                          preloadCurrent,
  output logic [15:0]                          startEventCounter,
  output logic [15:0]                          tripEventCounter,
  output var thermal_overload_pkg::hms_t       timeToTrip,
  output logic                                 forceFlag,
  output thermal_overload_pkg::settings_t      settingsOut
);
  function automatic logic [15:0] isqrt(input logic [31:0] x);
    logic [15:0] r;
    r = 16'h0;
    for (int b = 15; b >= 0; b--) begin
      if (32'(r | (16'h1 << b)) * 32'(r | (16'h1 << b)) <= x) r = r | (16'h1 << b);
    end
    return r;
  endfunction
  function automatic logic [31:0] sat32(input logic [63:0] x);
    return (x[63:32] != 32'h0) ? 32'hffff_ffff : x[31:0];
  endfunction
  function automatic logic [12:0] log2q8(input logic [31:0] x);
    logic [4:0]  p;
    logic [31:0] m;
    p = 5'h0;
    for (int b = 0; b < 32; b++) begin
      if (x[b]) p = 5'(b);
    end
    m = (p >= 5'h8) ? (x >> (p - 5'h8)) : (x << (5'h8 - p));
    return {p, m[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // rms accumulation
  logic [35:0] acc_ff   [3];
  logic [35:0] nxt_acc  [3];
  logic [31:0] phaseSq_ff [3];
  logic [31:0] iSq_ff;
  wire  logic [31:0] ampSq = 32'(harm.amp) * 32'(harm.amp);
  wire  logic harmOk = harm.valid && harm.order != 5'h0 && harm.order <= `ORDER_MAX;
  wire  logic [31:0] max01 = (phaseSq_ff[0] > phaseSq_ff[1]) ? phaseSq_ff[0] : phaseSq_ff[1];
  wire  logic [31:0] maxSq = (max01 > phaseSq_ff[2]) ? max01 : phaseSq_ff[2];
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      nxt_acc[p] = acc_ff[p] + ((harmOk && harm.phase == 2'(p)) ? 36'(ampSq) : 36'h0);
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < 3; p++) begin
        acc_ff[p]     <= 36'h0;
        phaseSq_ff[p] <= 32'h0;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (harm.valid && harm.last) begin
          acc_ff[p]     <= 36'h0;
          phaseSq_ff[p] <= sat32(64'(nxt_acc[p]));
        end else begin
          acc_ff[p] <= nxt_acc[p];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // settings
  thermal_overload_pkg::settings_t set_ff;
  wire logic protOk = setWr && passwordOk;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      set_ff <= '{`DEF_K, `DEF_ALARM, `DEF_LIM40, `DEF_LIM70, `DEF_AMB, 5'h0,
                  `DEF_TAU, `DEF_CTAU};
    end else begin
      if (protOk && setSel == thermal_overload_pkg::SET_K) set_ff.k <= setData;
      if (protOk && setSel == thermal_overload_pkg::SET_ALARM) set_ff.alarm <= setData[7:0];
      if (protOk && setSel == thermal_overload_pkg::SET_LIM40) set_ff.lim40 <= setData[7:0];
      if (protOk && setSel == thermal_overload_pkg::SET_LIM70) set_ff.lim70 <= setData[7:0];
      if (protOk && setSel == thermal_overload_pkg::SET_AMB && set_ff.sensor == 5'h0)
        set_ff.amb <= setData[7:0];
      if (protOk && setSel == thermal_overload_pkg::SET_SENSOR && setData <= 16'h10)
        set_ff.sensor <= setData[4:0];
      if (setWr && setSel == thermal_overload_pkg::SET_TAU) set_ff.tau <= setData;
      if (setWr && setSel == thermal_overload_pkg::SET_CTAU) set_ff.ctau <= setData[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ambient factor and trip current
  wire logic signed [7:0] ambNow = (set_ff.sensor == 5'h0) ? set_ff.amb
                                   : externalAnalogueInput[4'(set_ff.sensor - 5'h1)];
  int          limPct;
  logic [15:0] kth;
  always_comb begin
    limPct = int'(set_ff.lim40) + ((int'(set_ff.lim70) - int'(set_ff.lim40))
             * (int'(ambNow) - `AMB_LOW)) / `AMB_SPAN;
    if (limPct < 0) limPct = 0;
    if (set_ff.lim40 == `DEF_LIM40 || set_ff.sensor == 5'h0 || int'(ambNow) == `AMB_LOW)
      kth = `KTH_ONE;
    else
      kth = 16'((limPct * 256) / 100);
  end
  wire logic [15:0] imode = motorMode ? motorRatedCurrent : lineRated;
  wire logic [31:0] kk = 32'(set_ff.k) * 32'(kth);
  wire logic [47:0] itFull = (48'(kk) * 48'(imode)) >> 16;
  wire logic [15:0] itrip = (itFull[47:16] != 32'h0) ? 16'hffff : itFull[15:0];
  wire logic [31:0] itSq = 32'(itrip) * 32'(itrip);

  ////////////////////////////////////////////////////////////////////////
  // thermal state
  logic [31:0] theta_ff;
  logic [23:0] evalCnt_ff;
  logic        frcHeld_ff;
  wire  logic  tick = evalCnt_ff == EVAL_CYC - 24'h1;
  wire  logic [31:0] ipSq = sat32((64'(theta_ff) * 64'(itSq)) >> 24);
  wire  logic [31:0] target = (itSq == 32'h0) ? 32'hffff_ffff
                              : sat32((64'(iSq_ff) << 24) / 64'(itSq));
  wire  logic cooling = 40'(iSq_ff) * `COOL_DEN
                        < `COOL_NUM * 40'(32'(motorRatedCurrent) * 32'(motorRatedCurrent));
  wire  logic [31:0] tauBase = 32'(set_ff.tau) * 32'(PER_MIN);
  wire  logic [39:0] tauCool = (40'(tauBase) * 40'(set_ff.ctau)) >> 4;
  wire  logic [31:0] tauAct = cooling ? sat32(64'(tauCool)) : tauBase;
  wire  logic signed [33:0] diff = 34'(target) - 34'(theta_ff);
  wire  logic signed [33:0] delta = diff / $signed({2'b00, (tauAct == 32'h0) ? 32'h1 : tauAct});
  wire  logic [33:0] thetaSum = 34'(theta_ff) + 34'(delta);
  wire  logic [31:0] nxt_theta = thetaSum[33] ? 32'h0 : (thetaSum[32] ? 32'hffff_ffff
                                                        : thetaSum[31:0]);
  wire  logic [63:0] frcTheta = (64'(frcPct) << 24) / `PCT_FULL;
  wire  logic relTrip = 64'(iSq_ff) * `PCT_FULL < `REL_NUM * 64'(itSq);
  wire  logic relStart = 64'(iSq_ff) * `PCT_FULL * `PCT_FULL
                         < `REL_NUM * 64'(set_ff.alarm) * 64'(itSq);
  wire  logic [63:0] startLvl = (64'(`THETA_ONE) * 64'(set_ff.alarm)) / `PCT_FULL;
  wire  logic frcOk = frcWr && forceFlag;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      theta_ff   <= `THETA_INIT;
      evalCnt_ff <= 24'h0;
      iSq_ff     <= 32'h0;
      status     <= '0;
    end else begin
      iSq_ff     <= maxSq;
      evalCnt_ff <= tick ? 24'h0 : evalCnt_ff + 24'h1;
      if (frcOk) begin
        status   <= frcStatus;
        theta_ff <= sat32(frcTheta);
      end else if (tick && !frcHeld_ff) begin
        theta_ff       <= nxt_theta;
        status.blocked <= blockIn;
        status.trip <= !blockIn && (status.trip ? !relTrip : nxt_theta >= `THETA_ONE);
        status.start <= !blockIn && (status.start ? !relStart
                                                  : 64'(nxt_theta) >= startLvl);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // force flag and timeout
  logic [35:0] frcCnt_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      forceFlag  <= 1'b0;
      frcCnt_ff  <= 36'h0;
      frcHeld_ff <= 1'b0;
    end else begin
      frcCnt_ff <= (forceFlag && !forceReq) ? frcCnt_ff + 36'h1 : 36'h0;
      if (forceReq) forceFlag <= 1'b1;
      else if (forceClr || frcCnt_ff == FORCE_CYC - 36'h1) forceFlag <= 1'b0;
      if (!forceFlag) frcHeld_ff <= 1'b0;
      else if (frcOk) frcHeld_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counters
  logic startPrev_ff;
  logic tripPrev_ff;
  wire  logic startRise = status.start && !startPrev_ff;
  wire  logic tripRise = status.trip && !tripPrev_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      startPrev_ff      <= 1'b0;
      tripPrev_ff       <= 1'b0;
      startEventCounter <= 16'h0;
      tripEventCounter  <= 16'h0;
    end else begin
      startPrev_ff <= status.start;
      tripPrev_ff  <= status.trip;
      if (startClr) startEventCounter <= startRise ? 16'h1 : 16'h0;
      else if (startRise) startEventCounter <= startEventCounter + 16'h1;
      if (tripClr) tripEventCounter <= tripRise ? 16'h1 : 16'h0;
      else if (tripRise) tripEventCounter <= tripEventCounter + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time to trip and reported values
  wire logic heating = iSq_ff > itSq && iSq_ff > ipSq;
  wire logic signed [14:0] lnDiff = 15'(log2q8(iSq_ff - ipSq)) - 15'(log2q8(iSq_ff - itSq));
  wire logic [47:0] tauSec = 48'(set_ff.tau) * 48'd60;
  wire logic [47:0] secFull = lnDiff[14] ? 48'h0
                              : (tauSec * 48'(lnDiff) * `LN2_Q8) >> 16;
  wire logic [31:0] secs = sat32(64'(secFull));
  wire logic [31:0] hrs = secs / 32'd3600;
  wire logic [31:0] rem = secs % 32'd3600;
  // rounded to nearest so 0.7 in Q24 reads as 70
  wire logic [63:0] pctFull = (64'(theta_ff) * `PCT_FULL + 64'h80_0000) >> 24;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timeToTrip              <= '0;
      thetaPct                <= 16'h0;
      highestPhaseCurrent     <= 16'h0;
      ambientCorrectedCurrent <= 16'h0;
      preloadCurrent          <= 16'h0;
      settingsOut             <= '0;
    end else begin
      timeToTrip.valid   <= heating && !status.trip;
      timeToTrip.hours   <= (hrs > 32'hffff) ? 16'hffff : hrs[15:0];
      timeToTrip.minutes <= 6'(rem / 32'd60);
      timeToTrip.seconds <= 6'(rem % 32'd60);
      thetaPct <= (pctFull[63:16] != 48'h0) ? 16'hffff : pctFull[15:0];
      highestPhaseCurrent     <= isqrt(iSq_ff);
      ambientCorrectedCurrent <= (kk[31:24] != 8'h0) ? 16'hffff : kk[23:8];
      preloadCurrent <= isqrt(ipSq);
      settingsOut    <= set_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence forceArm;
    forceReq ##1 forceFlag;
  endsequence
  a_force_set: assert property (@(posedge clk) disable iff (!nrst)
    forceReq |-> forceArm) else $error("force flag not set");
  a_force_timeout: assert property (@(posedge clk) disable iff (!nrst)
    forceFlag && frcCnt_ff == FORCE_CYC - 36'h1 && !forceReq |=> !forceFlag)
    else $error("force flag outlived timeout");
  a_forced_reject: assert property (@(posedge clk) disable iff (!nrst)
    frcWr && !forceFlag && !tick |=> $stable(status) && $stable(theta_ff))
    else $error("forced write accepted without flag");
  a_init_rise: assert property (@(posedge clk)
    $rose(nrst) |-> theta_ff == `THETA_INIT) else $error("initial rise wrong");
  a_trip_level: assert property (@(posedge clk) disable iff (!nrst)
    tick && !frcHeld_ff && !frcOk && !blockIn && !status.trip && nxt_theta >= `THETA_ONE
    |=> status.trip) else $error("no trip at full rise");
  a_password_gate: assert property (@(posedge clk) disable iff (!nrst)
    setWr && !passwordOk && setSel != thermal_overload_pkg::SET_TAU
    && setSel != thermal_overload_pkg::SET_CTAU |=> $stable(set_ff))
    else $error("protected setting changed without password");
  a_amb_lock: assert property (@(posedge clk) disable iff (!nrst)
    set_ff.sensor != 5'h0 |=> $stable(set_ff.amb)) else $error("ambient edited with sensor");
  a_cnt_clear: assert property (@(posedge clk) disable iff (!nrst)
    startClr && !startRise |=> startEventCounter == 16'h0) else $error("start count kept");
  a_max_phase: assert property (@(posedge clk) disable iff (!nrst)
    ##1 iSq_ff >= $past(phaseSq_ff[0]) && iSq_ff >= $past(phaseSq_ff[1])
    && iSq_ff >= $past(phaseSq_ff[2])) else $error("not highest phase");
  a_order_gate: assert property (@(posedge clk) disable iff (!nrst)
    harm.valid && harm.order > `ORDER_MAX && !harm.last |=> $stable(acc_ff[0])
    && $stable(acc_ff[1]) && $stable(acc_ff[2])) else $error("harmonic above 15 used");
endmodule

/* verif/harmonic_source.sv */
/*
  Front end model: streams harmonic samples of three phases, ten a cycle.
  Assumes clk and nrst from the bench; amplitudes change between cycles.
*/
`timescale 1ns/100ps
module harmonic_source (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [2:0][15:0]       fund,
  input  wire logic [2:0][15:0]       h15,
  output var thermal_overload_pkg::harm_t harm
);
  logic [3:0]                  idx;
  thermal_overload_pkg::harm_t nxtHarm;
  ////////////////////////////////////////////////////////////////////////
  // sample table, stray samples must be ignored by the stage
  always_comb begin
    nxtHarm       = '0;
    nxtHarm.valid = 1'b1;
    case (idx)
      4'h0: {nxtHarm.phase, nxtHarm.order, nxtHarm.amp} = {2'h0, 5'h01, fund[0]};
      4'h1: {nxtHarm.phase, nxtHarm.order, nxtHarm.amp} = {2'h0, 5'h0f, h15[0]};
      4'h2: {nxtHarm.phase, nxtHarm.order, nxtHarm.amp} = {2'h0, 5'h10, 16'hffff};
      4'h3: {nxtHarm.phase, nxtHarm.order, nxtHarm.amp} = {2'h1, 5'h01, fund[1]};
      4'h4: {nxtHarm.phase, nxtHarm.order, nxtHarm.amp} = {2'h1, 5'h0f, h15[1]};
      4'h5: {nxtHarm.phase, nxtHarm.order, nxtHarm.amp} = {2'h2, 5'h01, fund[2]};
      4'h6: {nxtHarm.phase, nxtHarm.order, nxtHarm.amp} = {2'h2, 5'h0f, h15[2]};
      4'h7: {nxtHarm.phase, nxtHarm.order, nxtHarm.amp} = {2'h3, 5'h01, 16'hffff};
      4'h8: {nxtHarm.phase, nxtHarm.order, nxtHarm.amp} = {2'h1, 5'h00, 16'hffff};
      default: begin
        {nxtHarm.phase, nxtHarm.order, nxtHarm.amp} = {2'h2, 5'h02, 16'h0000};
        nxtHarm.last = 1'b1;
      end
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx  <= 4'h0;
      harm <= '0;
    end else begin
      idx  <= (idx == 4'h9) ? 4'h0 : idx + 4'h1;
      harm <= nxtHarm;
    end
  end
endmodule

/* verif/thermal_overload_model_test.sv */
/*
  Self-checking bench of the thermal overload stage with a harmonic source.
  Assumes short evaluation and force periods set through parameters.
*/
`timescale 1ns/100ps
module thermal_overload_model_test;
  logic                            clk = 1'b0;
  logic                            nrst = 1'b0;
  logic [2:0][15:0]                fund = '0;
  logic [2:0][15:0]                h15 = '0;
  logic                            motorMode = 1'b0;
  logic                            blockIn = 1'b0;
  logic [15:0][7:0]                externalAnalogueInput = '0;
  logic                            setWr = 1'b0;
  thermal_overload_pkg::setting_t  setSel = thermal_overload_pkg::SET_K;
  logic [15:0]                     setData = '0;
  logic                            passwordOk = 1'b0;
  logic                            forceReq = 1'b0;
  logic                            forceClr = 1'b0;
  logic                            frcWr = 1'b0;
  thermal_overload_pkg::status_t   frcStatus = '0;
  logic [15:0]                     frcPct = '0;
  logic                            startClr = 1'b0;
  logic                            tripClr = 1'b0;
  thermal_overload_pkg::harm_t     harm;
  thermal_overload_pkg::status_t   status;
  thermal_overload_pkg::hms_t      timeToTrip;
  thermal_overload_pkg::settings_t settingsOut;
  logic [15:0]                     thetaPct, highestPhaseCurrent, ambientCorrectedCurrent;
  logic [15:0]                     preloadCurrent, startEventCounter, tripEventCounter;
  logic                            forceFlag;
  int                              errors = 0;
  int                              checked = 0;
  int                              cycles = 0;
  int                              n;
  initial forever #12.5 clk = ~clk;
  harmonic_source src (.clk(clk), .nrst(nrst), .fund(fund), .h15(h15), .harm(harm));
  thermal_overload_model #(.FORCE_CYC(36'd200), .EVAL_CYC(24'd16), .PER_MIN(1)) DUT (
    .clk(clk), .nrst(nrst), .harm(harm), .motorMode(motorMode), .lineRated(16'h0064),
    .motorRatedCurrent(16'h0050), .blockIn(blockIn), .externalAnalogueInput(externalAnalogueInput),
    .setWr(setWr), .setSel(setSel), .setData(setData), .passwordOk(passwordOk),
    .forceReq(forceReq), .forceClr(forceClr), .frcWr(frcWr), .frcStatus(frcStatus),
    .frcPct(frcPct), .startClr(startClr), .tripClr(tripClr), .status(status),
    .thetaPct(thetaPct), .highestPhaseCurrent(highestPhaseCurrent),
    .ambientCorrectedCurrent(ambientCorrectedCurrent), .preloadCurrent(preloadCurrent),
    .startEventCounter(startEventCounter), .tripEventCounter(tripEventCounter),
    .timeToTrip(timeToTrip), .forceFlag(forceFlag), .settingsOut(settingsOut));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic setw(input thermal_overload_pkg::setting_t s, input logic [15:0] d,
                      input logic p);
    @(posedge clk);
    setWr      <= 1'b1;
    setSel     <= s;
    setData    <= d;
    passwordOk <= p;
    @(posedge clk);
    setWr <= 1'b0;
    cyc(3);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    cyc(4);
    chk("thetaPct", thetaPct, 36'h46);
    chk("preload", preloadCurrent >= 16'h0053 && preloadCurrent <= 16'h0054, 1);
    chk("k", settingsOut.k, 36'h100);
    chk("ctau", settingsOut.ctau, 36'h10);
    chk("lim40", settingsOut.lim40, 36'h64);
    chk("amb", settingsOut.amb, 36'h28);
    chk("sensor", settingsOut.sensor, 36'h0);
    chk("iTrip", ambientCorrectedCurrent, 36'h100);
    $display("test defaults done");
    setw(thermal_overload_pkg::SET_ALARM, 16'h0050, 1'b0);
    chk("alarm", settingsOut.alarm, 36'h3c);
    setw(thermal_overload_pkg::SET_ALARM, 16'h0050, 1'b1);
    chk("alarm", settingsOut.alarm, 36'h50);
    setw(thermal_overload_pkg::SET_ALARM, 16'h003c, 1'b1);
    motorMode <= 1'b1;
    cyc(40);
    chk("iTrip", ambientCorrectedCurrent, 36'h100);
    motorMode <= 1'b0;
    setw(thermal_overload_pkg::SET_LIM40, 16'h0050, 1'b1);
    setw(thermal_overload_pkg::SET_LIM70, 16'h0032, 1'b1);
    setw(thermal_overload_pkg::SET_SENSOR, 16'h0011, 1'b1);
    chk("sensor", settingsOut.sensor, 36'h0);
    externalAnalogueInput[0] <= 8'h37;
    setw(thermal_overload_pkg::SET_SENSOR, 16'h0001, 1'b1);
    setw(thermal_overload_pkg::SET_AMB, 16'h0032, 1'b1);
    chk("amb", settingsOut.amb, 36'h28);
    cyc(40);
    chk("iTrip", ambientCorrectedCurrent, 36'ha6);
    externalAnalogueInput[0] <= 8'h28;
    cyc(40);
    chk("iTrip", ambientCorrectedCurrent, 36'h100);
    setw(thermal_overload_pkg::SET_SENSOR, 16'h0000, 1'b1);
    setw(thermal_overload_pkg::SET_AMB, 16'h0032, 1'b1);
    chk("amb", settingsOut.amb, 36'h32);
    setw(thermal_overload_pkg::SET_LIM40, 16'h0064, 1'b1);
    $display("test settings done");
    fund <= {16'h003c, 16'h0000, 16'h0042};
    h15  <= {16'h0000, 16'h0000, 16'h0058};
    for (n = 0; n < 100 && highestPhaseCurrent !== 16'h006e; n++) cyc(1);
    chk("iMax", highestPhaseCurrent, 36'h6e);
    cyc(20);
    chk("ttValid", timeToTrip.valid, 1);
    chk("ttTime", timeToTrip.hours == 16'h0 && timeToTrip.minutes != 6'h0, 1);
    for (n = 0; n < 3000 && status.trip !== 1'b1; n++) cyc(1);
    cyc(2);
    chk("trip", status.trip, 1);
    chk("start", status.start, 1);
    chk("pct", thetaPct >= 16'h0064, 1);
    chk("tripCnt", tripEventCounter, 36'h1);
    chk("ttValid", timeToTrip.valid, 0);
    fund <= '0;
    h15  <= '0;
    for (n = 0; n < 300 && status.trip !== 1'b0; n++) cyc(1);
    cyc(2);
    chk("status", status, 36'h0);
    @(posedge clk);
    tripClr  <= 1'b1;
    startClr <= 1'b1;
    @(posedge clk);
    tripClr  <= 1'b0;
    startClr <= 1'b0;
    cyc(1);
    chk("tripCnt", tripEventCounter, 36'h0);
    chk("startCnt", startEventCounter, 36'h0);
    $display("test heating done");
    @(posedge clk);
    frcWr     <= 1'b1;
    frcStatus <= 3'b001;
    @(posedge clk);
    frcWr <= 1'b0;
    cyc(3);
    chk("status", status, 36'h0);
    @(posedge clk);
    forceReq <= 1'b1;
    @(posedge clk);
    forceReq  <= 1'b0;
    frcWr     <= 1'b1;
    frcStatus <= 3'b010;
    frcPct    <= 16'h0032;
    @(posedge clk);
    frcWr <= 1'b0;
    cyc(40);
    chk("status", status, 36'h2);
    chk("pct", thetaPct, 36'h32);
    chk("preload", preloadCurrent, 36'h46);
    motorMode <= 1'b1;
    cyc(3);
    chk("preload", preloadCurrent, 36'h38);
    motorMode <= 1'b0;
    chk("startCnt", startEventCounter, 36'h1);
    @(posedge clk);
    forceClr <= 1'b1;
    @(posedge clk);
    forceClr <= 1'b0;
    cyc(1);
    chk("flag", forceFlag, 0);
    @(posedge clk);
    forceReq <= 1'b1;
    @(posedge clk);
    forceReq <= 1'b0;
    cyc(100);
    chk("flag", forceFlag, 1);
    cyc(110);
    chk("flag", forceFlag, 0);
    $display("test force done");
    blockIn <= 1'b1;
    cyc(20);
    chk("status", status, 36'h4);
    blockIn <= 1'b0;
    cyc(20);
    chk("status", status, 36'h0);
    $display("test block done");
    final_report;
  end
endmodule
